// ---- include/gpp_pkg.sv ----
// Package for the general purpose I/O port with three modulated outputs.
// Assumes a single 25 MHz system clock derived from the external oscillator.
package gpp_pkg;
  localparam int          GPP_PINS        = 8;
  localparam int          GPP_PWM_CH      = 3;
  localparam int          GPP_DIV_W       = 16;
  localparam int          GPP_PCT_W       = 7;
  localparam logic [6:0]  GPP_PCT_FULL    = 7'h64;
  localparam logic [6:0]  GPP_PCT_ZERO    = 7'h00;
  localparam logic [15:0] GPP_DIV_RESET   = 16'h0063;
  localparam logic [6:0]  GPP_STEP_LAST   = 7'h63;
  localparam int          GPP_PWM_PIN0    = 0;
  localparam int          GPP_CLK_MHZ     = 25;

  // Pin function selection: general purpose, modulated output or claimed by another block.
  typedef enum logic [1:0] {GPP_FN_GPIO, GPP_FN_PWM, GPP_FN_ALT} gpp_fn_t;

  // Shared modulation settings applied together at a period boundary.
  typedef struct packed {
    logic [GPP_DIV_W-1:0]                  div;
    logic [GPP_PWM_CH-1:0][GPP_PCT_W-1:0] duty;
  } gpp_pwm_cfg_t;

  // Pad drive for one pin.
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } gpp_pad_t;
endpackage

// ---- src/gpp_pwm.sv ----
// Three channel modulator with a shared period and per channel duty in percent.
// Assumes settings are held stable by the caller; they are latched at period boundaries.
`timescale 1ns/100ps
module gpp_pwm
  import gpp_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  run,
  input  wire gpp_pwm_cfg_t          cfg,
  output logic [GPP_PWM_CH-1:0]      pwm_out
);
  gpp_pwm_cfg_t         act_reg;
  logic [GPP_DIV_W-1:0] pre_reg;
  logic [GPP_PCT_W-1:0] step_reg;
  logic                 pre_wrap;
  logic                 period_end;

  ////////////////////////////////////////////////////////////////////////////
  // Each period is one hundred steps; each step lasts div plus one clocks.
  assign pre_wrap   = (pre_reg >= act_reg.div);
  assign period_end = pre_wrap && (step_reg == GPP_STEP_LAST);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_reg  <= '0;
      step_reg <= '0;
      act_reg  <= '{div: GPP_DIV_RESET, duty: '0};
    end
    else if (!run)
    begin
      pre_reg  <= '0;
      step_reg <= '0;
      act_reg  <= cfg;
    end
    else if (pre_wrap)
    begin
      pre_reg  <= '0;
      step_reg <= period_end ? '0 : step_reg + 7'h01;
      if (period_end)
        act_reg <= cfg;
    end
    else
      pre_reg <= pre_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // High while the step index is below the duty; 100 holds high, 0 holds low.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      pwm_out <= '0;
    else
      for (int i = 0; i < GPP_PWM_CH; i++)
        pwm_out[i] <= run && (act_reg.duty[i] >= GPP_PCT_FULL || step_reg < act_reg.duty[i]);
  end

  a_full_duty_high : assert property (@(posedge clock) disable iff (sys_rst)
    (run && act_reg.duty[0] >= GPP_PCT_FULL) |=> pwm_out[0])
    else $error("Full duty channel went low.");

  a_zero_duty_low : assert property (@(posedge clock) disable iff (sys_rst)
    (act_reg.duty[1] == GPP_PCT_ZERO) |=> !pwm_out[1])
    else $error("Zero duty channel went high.");

  a_cfg_held_mid : assert property (@(posedge clock) disable iff (sys_rst)
    (run && $past(run) && !$past(period_end)) |-> $stable(act_reg))
    else $error("Settings changed inside a period.");

endmodule // gpp_pwm

// ---- src/gpp_port.sv ----
// Top of the general purpose I/O port: direction, function select, inputs and modulated outputs.
// Assumes pads resolve out/oe/pu externally; pins arrive asynchronously.
`timescale 1ns/100ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter int PINS = GPP_PINS
)
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  prog_run,
  input  wire logic [PINS-1:0]       pin_in,
  input  wire logic [PINS-1:0]       dir_out,
  input  wire logic [PINS-1:0]       out_val,
  input  wire logic [PINS-1:0]       alt_claim,
  input  wire logic [GPP_PWM_CH-1:0] pwm_sel,
  input  wire gpp_pwm_cfg_t          pwm_cfg,
  output logic [PINS-1:0]            in_val,
  output logic [PINS-1:0]            pad_out,
  output logic [PINS-1:0]            pad_oe,
  output logic [PINS-1:0]            pad_pu
);
// Behaviour
// - Input reads true when the pin is low.
// - Output pin high when program sets it true, low otherwise.
// - Before program start every pin pulls up with driver off.
// - No debounce or filtering on inputs.
// - Each pin has its own direction unless claimed elsewhere.
// - One function per pin; alternate claim disables general control.
// - Three modulated channels, 0 to 2, on dedicated pins.
// - Channels share one period, each keeps its own duty.
// - Frequency may change while running, without reset.
// - Duty in percent; one hundred percent holds output on.
// - Modulated pins idle and pulled up before program start.
// - Modulated pin is either modulated output or ordinary pin; in the code alt_claim can also take pins 0 to 2 as alternate.
// - All timing comes from the one oscillator clock.

  logic [PINS-1:0]       sync1_reg;
  logic [PINS-1:0]       sync2_reg;
  logic                  run_s1_reg;
  logic                  run_reg;
  logic [GPP_PWM_CH-1:0] pwm_wave;
  gpp_fn_t               fn     [PINS];
  gpp_pad_t              pad_next [PINS];

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs and program start pass two flip-flops.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_reg  <= '1;
      sync2_reg  <= '1;
      run_s1_reg <= 1'b0;
      run_reg    <= 1'b0;
    end
    else
    begin
      sync1_reg  <= pin_in;
      sync2_reg  <= sync1_reg;
      run_s1_reg <= prog_run;
      run_reg    <= run_s1_reg;
    end
  end

  gpp_pwm u_pwm (
    .clock   (clock),
    .sys_rst (sys_rst),
    .run     (run_reg),
    .cfg     (pwm_cfg),
    .pwm_out (pwm_wave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Function select and pad drive per pin.
  for (genvar p = 0; p < PINS; p++)
  begin : g_pin
    localparam int CH = p - GPP_PWM_PIN0;
    localparam bit IS_PWM = (p >= GPP_PWM_PIN0) && (p < GPP_PWM_PIN0 + GPP_PWM_CH);
    assign fn[p] = alt_claim[p] ? GPP_FN_ALT :
                   (IS_PWM && pwm_sel[IS_PWM ? CH : 0]) ? GPP_FN_PWM : GPP_FN_GPIO;
    always_comb
    begin
      pad_next[p] = '{out: 1'b0, oe: 1'b0, pu: 1'b1};
      if (run_reg)
        case (fn[p])
          GPP_FN_GPIO: pad_next[p] = '{out: out_val[p], oe: dir_out[p], pu: !dir_out[p]};
          GPP_FN_PWM:  pad_next[p] = '{out: pwm_wave[IS_PWM ? CH : 0], oe: 1'b1, pu: 1'b0};
          GPP_FN_ALT:  pad_next[p] = '{out: 1'b0, oe: 1'b0, pu: 1'b0};
          default:     pad_next[p] = '{out: 1'b0, oe: 1'b0, pu: 1'b1};
        endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      in_val  <= '0;
      pad_out <= '0;
      pad_oe  <= '0;
      pad_pu  <= '1;
    end
    else
      for (int p = 0; p < PINS; p++)
      begin
        in_val[p]  <= !sync2_reg[p] && fn[p] == GPP_FN_GPIO && !dir_out[p];
        pad_out[p] <= pad_next[p].out;
        pad_oe[p]  <= pad_next[p].oe;
        pad_pu[p]  <= pad_next[p].pu;
      end
  end

  a_idle_pullup : assert property (@(posedge clock) disable iff (sys_rst)
    !run_reg |=> (pad_oe == '0 && pad_pu == '1))
    else $error("Pin driven or not pulled up before start.");

  a_out_follows : assert property (@(posedge clock) disable iff (sys_rst)
    (run_reg && fn[1] == GPP_FN_GPIO && dir_out[1]) |=> (pad_oe[1] && pad_out[1] == $past(out_val[1])))
    else $error("Output pin does not follow its value.");

  a_in_low_true : assert property (@(posedge clock) disable iff (sys_rst)
    (fn[2] == GPP_FN_GPIO && !dir_out[2] && !sync2_reg[2]) |=> in_val[2])
    else $error("Low input not reported true.");

  a_alt_released : assert property (@(posedge clock) disable iff (sys_rst)
    alt_claim[3] |=> (!pad_oe[3] && !in_val[3]))
    else $error("Claimed pin still under general control.");

  a_pwm_drive : assert property (@(posedge clock) disable iff (sys_rst)
    (run_reg && fn[0] == GPP_FN_PWM) |=> (pad_oe[0] && pad_out[0] == $past(pwm_wave[0])))
    else $error("Modulated pin not driven by its channel.");

endmodule // gpp_port

// ---- dv/gpp_field.sv ----
// Field circuitry model facing the port pads.
// Assumes pad drive from gpp_port; a released unpulled line shows a changing level.
`timescale 1ns/100ps
module gpp_field
(
  input  wire logic       clock,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pu,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_in
);
  logic [7:0] last_reg;
  always_ff @(posedge clock) last_reg <= pin_in;
  assign pin_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pu | ~last_reg));
endmodule // gpp_field

// ---- dv/gpp_port_tb.sv ----
// Self-checking bench for gpp_port with a field model on the pads.
// Assumes a 25 MHz clock and the pad contract of the port.
`timescale 1ns/100ps
module gpp_port_tb;
  import gpp_pkg::*;
  logic         clock = 0, sys_rst = 1, prog_run = 0;
  logic [7:0]   dir_out = 0, out_val = 0, alt_claim = 0, ext_en = 0, ext_val = 0;
  logic [7:0]   pin_in, in_val, pad_out, pad_oe, pad_pu;
  logic [2:0]   pwm_sel = 0;
  gpp_pwm_cfg_t pwm_cfg = '0;
  int           mismatches = 0, n_checks = 0;
  always #20 clock = ~clock;
  gpp_port dut_u (.clock(clock), .sys_rst(sys_rst), .prog_run(prog_run), .pin_in(pin_in), .dir_out(dir_out),
    .out_val(out_val), .alt_claim(alt_claim), .pwm_sel(pwm_sel), .pwm_cfg(pwm_cfg), .in_val(in_val),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu));
  gpp_field field_u (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_idle;
    int bad = 0;
    @(posedge clock);
    dir_out <= 8'hFF; out_val <= 8'hFF; pwm_sel <= 3'h7; pwm_cfg.div <= 16'h0001; pwm_cfg.duty[0] <= 7'h32;
    repeat (300)
    begin
      cyc(1);
      if (pad_oe !== 8'h00 || pad_pu !== 8'hFF) bad++;
    end
    chk("idle", bad, 0);
  endtask
  task automatic t_in;
    int seen = 0;
    @(posedge clock);
    prog_run <= 1; dir_out <= 8'h00; pwm_sel <= 3'h0; ext_en <= 8'h0C; ext_val <= 8'h00;
    cyc(6);
    chk("in_low", in_val, 16'h000C);
    @(posedge clock) ext_val <= 8'h08;
    @(posedge clock) ext_val <= 8'h00;
    repeat (5)
    begin
      cyc(1);
      if (in_val[3] === 1'b0) seen = 1;
    end
    chk("glitch", seen, 1);
    @(posedge clock) ext_en <= 8'h00;
    cyc(5);
    chk("in_rel", in_val, 16'h0000);
  endtask
  task automatic t_out;
    @(posedge clock);
    dir_out <= 8'h32; out_val <= 8'h22;
    cyc(3);
    chk("oe", pad_oe & 8'h30, 16'h0030);
    chk("out", pad_out & 8'h32, 16'h0022);
    chk("pu", pad_pu, 16'h00CD);
    @(posedge clock) alt_claim <= 8'h28;
    cyc(3);
    chk("claim", pad_oe & 8'h30, 16'h0010);
    chk("claim_in", in_val & 8'h28, 16'h0000);
  endtask
  task automatic t_pwm(input logic [15:0] dv, input logic [6:0] d0, input logic [6:0] d1, input logic [6:0] d2);
    int p, hi[3];
    p = 100 * (dv + 1);
    hi = '{0, 0, 0};
    @(posedge clock);
    pwm_sel <= 3'h7; alt_claim <= 8'h00; pwm_cfg.div <= dv;
    pwm_cfg.duty[0] <= d0; pwm_cfg.duty[1] <= d1; pwm_cfg.duty[2] <= d2;
    cyc(3 * p);
    repeat (2 * p)
    begin
      cyc(1);
      for (int c = 0; c < 3; c++) if (pad_out[c] === 1'b1 && pad_oe[c] === 1'b1) hi[c]++;
    end
    chk("ch0", hi[0], 2 * d0 * (dv + 1));
    chk("ch1", hi[1], 2 * d1 * (dv + 1));
    chk("ch2", hi[2], 2 * d2 * (dv + 1));
  endtask
  task automatic t_sel;
    @(posedge clock);
    pwm_sel <= 3'h6; dir_out <= 8'h01; out_val <= 8'h00;
    cyc(3);
    chk("gpio0", {pad_oe[0], pad_out[0]}, 16'h0002);
  endtask
  initial
  begin
    #(40 * 20000);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge clock);
    sys_rst <= 0;
    t_idle();
    t_in();
    t_out();
    t_pwm(16'h0001, 7'h64, 7'h32, 7'h00);
    t_pwm(16'h0003, 7'h07, 7'h64, 7'h21);
    t_sel();
    end_of_test();
  end
endmodule // gpp_port_tb
